// File: hdl/clock_output_and_osc_trim.sv
// Clock output generator and oscillator trim registers on classic Wishbone
// Behaviour
// - Bits 6:4 choose output division ratio
// - Bits 3:2 choose fast, low, high, system
// - Ratios: powers of two; low adds long
// - System source output stops in sleep/halt
// - Bit 0 gates divided clock to pin
// - Enable change may truncate an output pulse
// - Bits 13:8 trim high-speed oscillator
// - Trim1 bits 5:0 trim fast oscillator
// - Trim2 bits 5:0 trim low-speed oscillator
// - Low trim ignored in crystal mode
// - Trims reset from loaded calibration inputs
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module clock_output_and_osc_trim (
  input  wire logic        i_mclk,               // 200 MHz block clock
  input  wire logic        i_rst,                // Asynchronous reset
  input  wire logic        i_wb_cyc,             // Wishbone cycle
  input  wire logic        i_wb_stb,             // Wishbone strobe
  input  wire logic        i_wb_we,              // Wishbone write
  input  wire logic [7:0]  i_wb_adr,             // Byte address
  input  wire logic [31:0] i_wb_dat,             // Write data
  input  wire logic [3:0]  i_wb_sel,             // Byte enables
  input  wire logic        i_fast_internal_clock, // Source pins, asynchronous
  input  wire logic        i_low_speed_clock,
  input  wire logic        i_high_speed_clock,
  input  wire logic        i_system_clock,
  input  wire logic        i_sleep,              // Standby flags, same clock
  input  wire logic        i_halt,
  input  wire logic        i_wp_unlocked,        // Write-protect key open
  input  wire logic        i_low_xtal_mode,      // Low-speed runs on crystal
  input  wire logic [5:0]  i_cal_fast_trim,      // Factory calibration values
  input  wire logic [5:0]  i_cal_high_trim,
  input  wire logic [5:0]  i_cal_low_trim,
  output logic [31:0]      o_wb_dat,             // Read data
  output logic             o_wb_ack,             // Wishbone acknowledge
  output logic             o_external_clock_out, // Divided clock to the pin
  output logic [5:0]       o_fast_internal_trim, // Trim codes to oscillators
  output logic [5:0]       o_high_speed_trim,
  output logic [5:0]       o_low_speed_trim,
  output logic             o_low_trim_apply      // Low trim in effect
);

  // Control fields
  logic [2:0]               out_div;       // out_divide_select
  logic [1:0]               out_src;       // out_source_select
  logic                     out_en;        // out_pin_enable
  clk_out_pkg::cal_state_e  cal_state;     // Calibration sequence
  logic [2:0]               next_div;
  logic [1:0]               next_src;
  logic                     next_en;
  logic [5:0]               next_fast;
  logic [5:0]               next_high;
  logic [5:0]               next_low;
  clk_out_pkg::cal_state_e  next_cal_state;
  // Bus
  logic                     next_ack;
  logic [31:0]              next_rdata;
  logic [7:0]               adr_word;      // Address with lane bits cleared
  logic                     wr;            // Write taken this edge
  logic                     ctrl_wr;       // Control byte written
  // Source path
  logic [3:0]               sync1;         // First stage, read by sync2 only
  logic [3:0]               sync2;         // Safe source levels
  logic                     sys_stopped;   // System source frozen
  logic                     invalid_ratio; // Reserved combination
  logic                     sel_level;
  logic [3:0]               shift;
  logic                     div_level;
  logic                     next_clk_out;
  logic                     next_apply;

  // Exponent of two for each source and division code
  function automatic logic [3:0] ratio_shift(input logic [1:0] src,
                                             input logic [2:0] div);
    logic [3:0] s;
    s = {1'b0, div};
    if (src == clk_out_pkg::SRC_LOW)
    begin
      case (div)
        3'h4:    s = clk_out_pkg::LOW_SHIFT_4;
        3'h5:    s = clk_out_pkg::LOW_SHIFT_5;
        3'h6:    s = clk_out_pkg::LOW_SHIFT_6;
        3'h7:    s = clk_out_pkg::LOW_SHIFT_7;
        default: s = {1'b0, div};
      endcase
    end
    else if (src == clk_out_pkg::SRC_SYS)
    begin
      s = 4'h0;
    end
    return s;
  endfunction : ratio_shift

  // Two stages per source pin before any logic looks at it
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end
        else
        begin
          sync1[g] <= (g == 0) ? i_fast_internal_clock :
                      (g == 1) ? i_low_speed_clock :
                      (g == 2) ? i_high_speed_clock : i_system_clock;
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  // Decode of the bus request; a write lands on the acknowledged edge
  always_comb
  begin
    adr_word = {i_wb_adr[7:2], 2'h0};
    wr       = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
    ctrl_wr  = wr && (adr_word == clk_out_pkg::ADR_OUT_CTRL) && i_wb_sel[0];
  end

  // Source selection; the system source is frozen in standby
  always_comb
  begin
    sys_stopped   = (out_src == clk_out_pkg::SRC_SYS) && (i_sleep || i_halt);
    invalid_ratio = (out_src == clk_out_pkg::SRC_SYS) && (out_div != 3'h0);
    sel_level     = sync2[out_src] && !sys_stopped && !invalid_ratio;
    shift         = ratio_shift(out_src, out_div);
  end

  // Divider restarts on any control write so a new ratio starts clean
  edge_count_divider u_div (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_src_level (sel_level),
    .i_shift     (shift),
    .i_restart   (ctrl_wr),
    .o_div_level (div_level)
  );

  // Register file next values
  always_comb
  begin
    next_div       = out_div;
    next_src       = out_src;
    next_en        = out_en;
    next_fast      = o_fast_internal_trim;
    next_high      = o_high_speed_trim;
    next_low       = o_low_speed_trim;
    next_cal_state = cal_state;
    // Control fields are not protected
    if (ctrl_wr)
    begin
      next_div = i_wb_dat[clk_out_pkg::DIV_LSB +: 3];
      next_src = i_wb_dat[clk_out_pkg::SRC_LSB +: 2];
      next_en  = i_wb_dat[clk_out_pkg::EN_BIT];
    end
    case (cal_state)
      // First cycle after reset takes the per-part values
      clk_out_pkg::CAL_LOAD:
      begin
        next_fast      = i_cal_fast_trim;
        next_high      = i_cal_high_trim;
        next_low       = i_cal_low_trim;
        next_cal_state = clk_out_pkg::CAL_RUN;
      end
      // Trim writes pass only through an open key; software is trusted
      // to stop the oscillator first, nothing here checks it
      clk_out_pkg::CAL_RUN:
      begin
        if (wr && i_wp_unlocked)
        begin
          if (adr_word == clk_out_pkg::ADR_TRIM1)
          begin
            if (i_wb_sel[1])
            begin
              next_high = i_wb_dat[clk_out_pkg::HIGH_TRIM_LSB +: 6];
            end
            if (i_wb_sel[0])
            begin
              next_fast = i_wb_dat[clk_out_pkg::FAST_TRIM_LSB +: 6];
            end
          end
          else if ((adr_word == clk_out_pkg::ADR_TRIM2) && i_wb_sel[0])
          begin
            next_low = i_wb_dat[clk_out_pkg::LOW_TRIM_LSB +: 6];
          end
        end
      end
      default:
      begin
        next_cal_state = clk_out_pkg::CAL_LOAD;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      out_div              <= clk_out_pkg::DIV_RST;
      out_src              <= clk_out_pkg::SRC_RST;
      out_en               <= clk_out_pkg::EN_RST;
      o_fast_internal_trim <= clk_out_pkg::TRIM_RST;
      o_high_speed_trim    <= clk_out_pkg::TRIM_RST;
      o_low_speed_trim     <= clk_out_pkg::TRIM_RST;
      cal_state            <= clk_out_pkg::CAL_LOAD;
    end
    else
    begin
      out_div              <= next_div;
      out_src              <= next_src;
      out_en               <= next_en;
      o_fast_internal_trim <= next_fast;
      o_high_speed_trim    <= next_high;
      o_low_speed_trim     <= next_low;
      cal_state            <= next_cal_state;
    end
  end

  // Bus answer: ack one cycle after the request, read data with it
  always_comb
  begin
    next_ack   = i_wb_cyc && i_wb_stb && !o_wb_ack;
    next_rdata = 32'h0000_0000;
    // Reserved and unmapped bits read zero
    if (next_ack && !i_wb_we)
    begin
      case (adr_word)
        clk_out_pkg::ADR_OUT_CTRL: next_rdata = {25'h0, out_div, out_src, 1'b0, out_en};
        clk_out_pkg::ADR_TRIM1:    next_rdata = {18'h0, o_high_speed_trim, 2'h0,
                                                 o_fast_internal_trim};
        clk_out_pkg::ADR_TRIM2:    next_rdata = {26'h0, o_low_speed_trim};
        clk_out_pkg::ADR_STATUS:   next_rdata = {28'h0, sys_stopped, invalid_ratio,
                                                 o_external_clock_out,
                                                 cal_state == clk_out_pkg::CAL_RUN};
        default:                   next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= next_ack;
      o_wb_dat <= next_rdata;
    end
  end

  // Pin gating; enable is not aligned to the divided clock, so a
  // shortened pulse is accepted rather than adding a retiming stage
  always_comb
  begin
    next_clk_out = div_level && out_en;
    next_apply   = !i_low_xtal_mode;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_external_clock_out <= 1'b0;
      o_low_trim_apply     <= 1'b0;
    end
    else
    begin
      o_external_clock_out <= next_clk_out;
      o_low_trim_apply     <= next_apply;
    end
  end

  // Checks on the design's own outputs
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // System source held in standby for three cycles
  sequence sys_held_s;
    ((out_src == clk_out_pkg::SRC_SYS) && (i_sleep || i_halt))[*3];
  endsequence

  div_write_a: assert property (
    ctrl_wr |=> (out_div == $past(i_wb_dat[6:4])))
    else $error("divide field not stored");
  src_write_a: assert property (
    ctrl_wr |=> (out_src == $past(i_wb_dat[3:2])))
    else $error("source field not stored");
  low_ratio_a: assert property (
    (out_src == clk_out_pkg::SRC_LOW) && (out_div == 3'h7) |-> (shift == 4'hF))
    else $error("low source 1/32768 exponent wrong");
  sys_stop_a: assert property (
    sys_held_s |-> !o_external_clock_out)
    else $error("output runs in standby on system source");
  pin_gate_a: assert property (
    !out_en |=> !o_external_clock_out)
    else $error("output active while disabled");
  pin_follow_a: assert property (
    out_en |=> (o_external_clock_out == $past(div_level)))
    else $error("output does not follow divider");
  high_trim_a: assert property (
    wr && i_wp_unlocked && i_wb_sel[1] && (adr_word == clk_out_pkg::ADR_TRIM1)
    && (cal_state == clk_out_pkg::CAL_RUN)
    |=> (o_high_speed_trim == $past(i_wb_dat[13:8])))
    else $error("high trim not stored");
  fast_trim_a: assert property (
    wr && i_wp_unlocked && i_wb_sel[0] && (adr_word == clk_out_pkg::ADR_TRIM1)
    && (cal_state == clk_out_pkg::CAL_RUN)
    |=> (o_fast_internal_trim == $past(i_wb_dat[5:0])))
    else $error("fast trim not stored");
  low_trim_a: assert property (
    wr && i_wp_unlocked && i_wb_sel[0] && (adr_word == clk_out_pkg::ADR_TRIM2)
    && (cal_state == clk_out_pkg::CAL_RUN)
    |=> (o_low_speed_trim == $past(i_wb_dat[5:0])))
    else $error("low trim not stored");
  xtal_mode_a: assert property (
    i_low_xtal_mode |=> !o_low_trim_apply)
    else $error("low trim applied in crystal mode");
  // The release edge itself still sees reset, so the load edge is the next one
  cal_load_a: assert property (
    !i_rst && (cal_state == clk_out_pkg::CAL_LOAD)
    |=> (o_fast_internal_trim == $past(i_cal_fast_trim))
        && (o_high_speed_trim == $past(i_cal_high_trim))
        && (o_low_speed_trim == $past(i_cal_low_trim)))
    else $error("calibration not loaded");
  trim_locked_a: assert property (
    wr && !i_wp_unlocked && (cal_state == clk_out_pkg::CAL_RUN)
    |=> $stable(o_high_speed_trim) && $stable(o_fast_internal_trim)
        && $stable(o_low_speed_trim))
    else $error("trim changed while locked");
  ctrl_reserved_a: assert property (
    o_wb_ack && !i_wb_we && (adr_word == clk_out_pkg::ADR_OUT_CTRL)
    |-> (o_wb_dat[31:7] == 25'h0) && !o_wb_dat[1])
    else $error("reserved control bits not zero");
  ack_pulse_a: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");

endmodule : clock_output_and_osc_trim

// File: include/clk_out_pkg.sv
// Constants and types shared by the clock output and oscillator trim block
package clk_out_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADR_OUT_CTRL = 8'h00;  // Clock output control
  localparam logic [7:0] ADR_TRIM1    = 8'h04;  // Fast and high-speed trim
  localparam logic [7:0] ADR_TRIM2    = 8'h08;  // Low-speed trim
  localparam logic [7:0] ADR_STATUS   = 8'h0C;  // Block status, read only

  // Field positions
  localparam int DIV_LSB       = 4;  // out_divide_select [6:4]
  localparam int SRC_LSB       = 2;  // out_source_select [3:2]
  localparam int EN_BIT        = 0;  // out_pin_enable [0]
  localparam int HIGH_TRIM_LSB = 8;  // high_speed_trim [13:8]
  localparam int FAST_TRIM_LSB = 0;  // fast_internal_trim [5:0]
  localparam int LOW_TRIM_LSB  = 0;  // low_speed_trim [5:0]

  // Values after reset
  localparam logic [2:0] DIV_RST  = 3'h0;
  localparam logic [1:0] SRC_RST  = 2'h0;
  localparam logic       EN_RST   = 1'b0;
  localparam logic [5:0] TRIM_RST = 6'h00;  // Held only until calibration loads

  // Output source codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_LOW  = 2'h1;
  localparam logic [1:0] SRC_HIGH = 2'h2;
  localparam logic [1:0] SRC_SYS  = 2'h3;

  // Low-speed divide exponents for codes 4 to 7
  localparam logic [3:0] LOW_SHIFT_4 = 4'h8;  // 1/256
  localparam logic [3:0] LOW_SHIFT_5 = 4'hA;  // 1/1,024
  localparam logic [3:0] LOW_SHIFT_6 = 4'hC;  // 1/4,096
  localparam logic [3:0] LOW_SHIFT_7 = 4'hF;  // 1/32,768

  // Width of the source edge counter, enough for 1/32,768
  localparam int CNT_W = 15;

  // Calibration load sequence
  typedef enum logic [0:0] {
    CAL_LOAD = 1'b0,
    CAL_RUN  = 1'b1
  } cal_state_e;

endpackage : clk_out_pkg

// File: hdl/edge_count_divider.sv
// Divides a synchronised source level by a power of two
`timescale 1ns/1ps
module edge_count_divider (
  input  wire logic       i_mclk,       // Block clock
  input  wire logic       i_rst,        // Asynchronous reset, active high
  input  wire logic       i_src_level,  // Synchronised source level
  input  wire logic [3:0] i_shift,      // Divide by two to this power
  input  wire logic       i_restart,    // Clear the counter
  output logic            o_div_level   // Divided level, registered
);

  logic                          prev;        // Source level one cycle ago
  logic [clk_out_pkg::CNT_W-1:0] count;       // Rising edges seen
  logic                          next_prev;
  logic [clk_out_pkg::CNT_W-1:0] next_count;
  logic                          next_div;

  // Count rising edges; counter bit k-1 has period 2^k source periods
  always_comb
  begin
    next_prev  = i_src_level;
    next_count = count;
    if (i_restart)
    begin
      next_count = '0;
    end
    else if (i_src_level && !prev)
    begin
      next_count = count + 15'h0001;
    end
    // Ratio 1/1 passes the level straight through
    if (i_shift == 4'h0)
    begin
      next_div = i_src_level;
    end
    else
    begin
      next_div = count[4'(i_shift - 4'h1)];
    end
  end

  // Registers only
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prev        <= 1'b0;
      count       <= '0;
      o_div_level <= 1'b0;
    end
    else
    begin
      prev        <= next_prev;
      count       <= next_count;
      o_div_level <= next_div;
    end
  end

endmodule : edge_count_divider

// File: verification/clk_sink_model.sv
// Source oscillators and a receiver that times the divided output clock
`timescale 1ns/1ps
module clk_sink_model (
  input  wire logic i_pin,    // Divided clock arriving from the block
  input  wire logic i_stop,   // Holds every oscillator still while high
  output logic      o_fast,   // Fast internal source
  output logic      o_low,    // Low-speed source
  output logic      o_high,   // High-speed source
  output logic      o_sys,    // System clock source
  output int        o_edges,  // Rising edges seen on the pin
  output realtime   o_period  // Time between the last two rising edges
);
  realtime last;  // Time of the previous rising edge

  // Periods are not multiples of the block clock, so phases drift freely
  initial
  begin
    o_fast = 1'b0;
    o_low = 1'b0;
    o_high = 1'b0;
    o_sys = 1'b0;
    o_edges = 0;
    o_period = 0.0;
    last = 0.0;
  end

  // Trims are only touched while the oscillators stand still
  always #20.5 if (!i_stop) o_fast = ~o_fast;
  always #13.5 if (!i_stop) o_low = ~o_low;
  always #16.5 if (!i_stop) o_high = ~o_high;
  always #23.5 if (!i_stop) o_sys = ~o_sys;

  // Receiver: the count changes last so a watcher sees a fresh period
  always @(posedge i_pin)
  begin
    o_period = $realtime - last;
    last = $realtime;
    o_edges++;
  end
endmodule : clk_sink_model

// File: verification/clock_output_and_osc_trim_tb.sv
// Self-checking bench for the clock output and oscillator trim block
`timescale 1ns/1ps
module clock_output_and_osc_trim_tb;
  typedef struct packed {
    logic        chk;  // Read whose data is compared
    logic [31:0] val;  // Expected read data
  } exp_s;

  logic i_mclk, i_rst, cyc, stb, we, slp, hlt, unl, xtal, stop;  // Bench drives
  logic [7:0]  adr;                       // Bus address
  logic [31:0] dat, rdat;                 // Write data, read data
  logic [3:0]  sel;                       // Byte lanes
  logic [5:0]  cal_f, cal_h, cal_l, ft, ht, lt;  // Calibration and expected trims
  logic        ack, pin, apply, fs, ls, hs, ss;
  logic [5:0]  o_f, o_h, o_l;             // Trim outputs
  int          edges, fails, cmp_count, skip, pe;
  realtime     period;
  exp_s        rd_q[$];                   // Notes of pending bus answers
  exp_s        x;
  int          per_q[$];                  // Expected output periods in ns
  int          per[4] = '{41, 27, 33, 47};  // Source periods in ns

  clock_output_and_osc_trim clock_output_and_osc_trim_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .i_fast_internal_clock(fs),
    .i_low_speed_clock(ls), .i_high_speed_clock(hs), .i_system_clock(ss),
    .i_sleep(slp), .i_halt(hlt), .i_wp_unlocked(unl), .i_low_xtal_mode(xtal),
    .i_cal_fast_trim(cal_f), .i_cal_high_trim(cal_h), .i_cal_low_trim(cal_l),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_external_clock_out(pin),
    .o_fast_internal_trim(o_f), .o_high_speed_trim(o_h), .o_low_speed_trim(o_l),
    .o_low_trim_apply(apply));

  clk_sink_model clk_sink_model_i (
    .i_pin(pin), .i_stop(stop), .o_fast(fs), .o_low(ls), .o_high(hs), .o_sys(ss),
    .o_edges(edges), .o_period(period));

  always #2.5 i_mclk = ~i_mclk;

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic timeout();
    fails++;
    $display("ERROR wait expected done seen timeout");
    conclude();
  endtask : timeout

  // One classic cycle; the note is queued before the request goes out
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] e);
    int n;
    rd_q.push_back({!w, e});
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      timeout();
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Skip two edges: the first pulse after a restart may be short
  task automatic measure(input int p);
    int n;
    skip = 2;
    per_q.push_back(p);
    n = 0;
    while (per_q.size() > 0 && n < 60000)
    begin
      @(posedge i_mclk);
      n++;
    end
    if (per_q.size() > 0)
      timeout();
  endtask : measure

  // The pin must stay low with no rising edge for a while
  task automatic quiet(input string nm);
    int e0;
    repeat (8) @(posedge i_mclk);
    e0 = edges;
    repeat (200) @(posedge i_mclk);
    chk(nm, e0, edges);
    chk(nm, 0, pin);
  endtask : quiet

  function automatic int ratio(input int s, input int d);
    if (s == 1 && d > 3)
      return (d == 7) ? 32768 : (256 << (2 * (d - 4)));
    return 1 << d;
  endfunction : ratio

  // Watcher of bus answers: every ack takes the oldest note
  always @(posedge i_mclk)
    if (ack === 1'b1)
    begin
      if (rd_q.size() == 0)
        chk("unexpected ack", 0, 1);
      else
      begin
        x = rd_q.pop_front();
        if (x.chk)
          chk("read data", x.val, rdat);
      end
    end

  // Watcher of the pin: sampling blurs each edge by up to one block clock;
  // a short settle lets the period port catch up with the edge count
  always @(edges)
  begin
    #0.1;
    if (skip > 0)
      skip--;
    else if (per_q.size() > 0)
    begin
      pe = per_q.pop_front();
      cmp_count++;
      if (period < pe - 6 || period > pe + 6)
      begin
        fails++;
        $display("ERROR output period expected %0d seen %0t", pe, period);
      end
    end
  end

  initial
  begin
    {i_mclk, cyc, stb, we, slp, hlt, xtal, stop, adr, dat, sel} = '0;
    {i_rst, unl} = 2'b11;
    {fails, cmp_count, skip, pe} = '0;
    void'($urandom(32'h68c9dd78));
    cal_f = 6'($urandom());
    cal_h = 6'($urandom());
    cal_l = 6'($urandom());
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk("fast trim", cal_f, o_f);
    chk("high trim", cal_h, o_h);
    chk("low trim", cal_l, o_l);
    chk("low apply", 1, apply);
    wb(0, clk_out_pkg::ADR_OUT_CTRL, 0, 0, 0);
    wb(0, clk_out_pkg::ADR_TRIM1, 0, 0, {cal_h, 2'h0, cal_f});
    wb(0, clk_out_pkg::ADR_TRIM2, 0, 0, {26'h0, cal_l});
    wb(0, clk_out_pkg::ADR_STATUS, 0, 0, 32'h1);
    wb(0, 8'h10, 0, 0, 0);
    wb(1, clk_out_pkg::ADR_OUT_CTRL, 32'hFFFF_FFFF, 4'hF, 0);
    wb(0, clk_out_pkg::ADR_OUT_CTRL, 0, 0, 32'h7D);
    // Trim updates with the key open and the oscillators held
    stop <= 1'b1;
    ht = 6'($urandom());
    ft = 6'($urandom());
    lt = 6'($urandom());
    wb(1, clk_out_pkg::ADR_TRIM1, {16'hFFFF, 2'h3, ht, 2'h3, ft}, 4'h3, 0);
    wb(1, clk_out_pkg::ADR_TRIM2, {26'h3FFFFFF, lt}, 4'h1, 0);
    wb(0, clk_out_pkg::ADR_TRIM1, 0, 0, {ht, 2'h0, ft});
    wb(0, clk_out_pkg::ADR_TRIM2, 0, 0, {26'h0, lt});
    wb(1, clk_out_pkg::ADR_TRIM1, {18'h0, ~ht, 8'h0}, 4'h2, 0);
    ht = ~ht;
    @(posedge i_mclk);
    chk("high trim", ht, o_h);
    chk("fast trim", ft, o_f);
    chk("low trim", lt, o_l);
    // Locked key: trim writes are acked but dropped
    unl <= 1'b0;
    wb(1, clk_out_pkg::ADR_TRIM1, 0, 4'h3, 0);
    wb(1, clk_out_pkg::ADR_TRIM2, 0, 4'h1, 0);
    wb(0, clk_out_pkg::ADR_TRIM1, 0, 0, {ht, 2'h0, ft});
    wb(0, clk_out_pkg::ADR_TRIM2, 0, 0, {26'h0, lt});
    stop <= 1'b0;
    xtal <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk("low apply", 0, apply);
    chk("low trim", lt, o_l);
    xtal <= 1'b0;
    // Every valid source and ratio; control stays writable while locked
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 8; d++)
      begin
        if (s == 3 && d > 0)
          continue;
        wb(1, clk_out_pkg::ADR_OUT_CTRL, {25'h0, d[2:0], s[1:0], 2'b01}, 4'h1, 0);
        // The longest low-speed ratios are only read back, timing them is too slow
        if (s == 1 && d > 5)
          wb(0, clk_out_pkg::ADR_OUT_CTRL, 0, 0, {25'h0, d[2:0], s[1:0], 2'b01});
        else
          measure(ratio(s, d) * per[s]);
      end
    slp <= 1'b1;
    quiet("sleep output");
    wb(0, clk_out_pkg::ADR_STATUS, 0, 0, 32'h9);
    slp <= 1'b0;
    hlt <= 1'b1;
    quiet("halt output");
    hlt <= 1'b0;
    measure(47);
    wb(1, clk_out_pkg::ADR_OUT_CTRL, 32'h1D, 4'h1, 0);
    quiet("reserved ratio");
    wb(0, clk_out_pkg::ADR_STATUS, 0, 0, 32'h5);
    wb(1, clk_out_pkg::ADR_OUT_CTRL, 32'h00, 4'h1, 0);
    quiet("disabled output");
    wb(1, clk_out_pkg::ADR_OUT_CTRL, 32'h01, 4'h1, 0);
    measure(41);
    conclude();
  end
endmodule : clock_output_and_osc_trim_tb
